// ===== bbs_pkg.sv
// Purpose: Shared constants and types for the branch and bit-set executor, plus its file memory.
// Assumes: One clock; each instruction cycle is four clock phases.
// Notes:   The file memory returns read data from a register one edge after the address.
// What this block does
// - Relative jump offset spans -1024..1023, adds twice it to the counter.
// - Jump target is instruction address plus 2 plus twice the offset.
// - Jump decoded from top nibble 1101 then a zero bit, eleven offset bits.
// - Jump takes two cycles: counter written in last phase, then a dead cycle.
// - Bit-set forces chosen bit 0..7 of register 0..4095 high, others kept.
// - Bit-set decoded from nibble 1000, bit index, bank-mode bit, address byte.
// - Bank-mode bit 0 takes the operand from the access bank.
// - Bank-mode bit 1 takes the bank from the bank pointer.
// - Bank-mode 0 with extended set uses indexed offset for addresses up to 5Fh.

package bbs_pkg;

   localparam logic [3:0]  OP_JUMP      = 4'hd;
   localparam logic [3:0]  OP_BITSET    = 4'h8;
   localparam logic [7:0]  ACCESS_SPLIT = 8'h80;
   localparam logic [7:0]  IDX_LIMIT    = 8'h5f;
   localparam logic [15:0] INSN_NOP     = 16'h0000;
   localparam int          PC_STEP      = 2;
   localparam int          PC_RESET     = 0;

   typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} bbs_phase_t;

   typedef struct packed
   {
      logic [3:0]  op;
      logic [2:0]  bit_idx;
      logic        bank_mode;
      logic [7:0]  file_addr;
   } bbs_bset_t;

   typedef struct packed
   {
      logic [3:0]  op;
      logic        zero;
      logic [10:0] offset;
   } bbs_jump_t;

endpackage

`timescale 1ns/100ps
`default_nettype none

module bbs_filemem #(
   parameter int AW = 12,
   parameter int DW = 8
) (
   // Clock and reset
   input  wire logic          i_clk_sys,
   input  wire logic          i_reset_n,
   // Read port for execution
   input  wire logic [AW-1:0] i_rd_addr,
   output logic      [DW-1:0] o_rd_data,
   // Observation port
   input  wire logic [AW-1:0] i_dbg_addr,
   output logic      [DW-1:0] o_dbg_data,
   // Write port
   input  wire logic          i_we,
   input  wire logic [AW-1:0] i_wr_addr,
   input  wire logic [DW-1:0] i_wr_data
);

   logic [DW-1:0] mem [0:(1<<AW)-1];

   // Array holds no reset; contents are undefined until written
   always_ff @(posedge i_clk_sys)
   begin
      if (i_we)
      begin
         mem[i_wr_addr] <= i_wr_data;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         o_rd_data  <= '0;
         o_dbg_data <= '0;
      end
      else
      begin
         o_rd_data  <= mem[i_rd_addr];
         o_dbg_data <= mem[i_dbg_addr];
      end
   end

endmodule

`default_nettype wire

// ===== bbs_exec.sv
// Purpose: Executes the unconditional relative jump and the single-bit set on a file register.
// Assumes: i_insn is valid on the edge that ends phase Q1 of a non-flush cycle.
// Notes:   Other opcodes pass through as one-cycle no-ops that only advance the counter.

`timescale 1ns/100ps
`default_nettype none

module bbs_exec #(
   parameter int PC_W = 21,
   parameter int AW   = 12
) (
   // Clock and reset
   input  wire logic            i_clk_sys,
   input  wire logic            i_reset_n,
   // Instruction stream
   input  wire logic [15:0]     i_insn,
   // Addressing context
   input  wire logic [AW-9:0]   i_bank_pointer,
   input  wire logic            i_ext_en,
   input  wire logic [AW-1:0]   i_index_base,
   // Observation of the file memory
   input  wire logic [AW-1:0]   i_dbg_addr,
   output logic      [7:0]      o_dbg_data,
   // Core state
   output logic      [PC_W-1:0] o_pc,
   output logic      [1:0]      o_phase,
   output logic                 o_flush,
   // Write-back report
   output logic                 o_wr_strobe,
   output logic      [AW-1:0]   o_wr_addr,
   output logic      [7:0]      o_wr_data
);

   ////////////////////////////////////////////////////////////////////////////////////////
   // Decode

   bbs_pkg::bbs_phase_t phase;
   bbs_pkg::bbs_phase_t next_phase;
   logic                flush;
   logic                next_flush;
   logic [15:0]         ir;
   logic [15:0]         next_ir;
   logic [PC_W-1:0]     pc;
   logic [PC_W-1:0]     next_pc;
   logic [AW-1:0]       addr;
   logic [AW-1:0]       next_addr;
   logic                next_wr_strobe;
   logic [AW-1:0]       next_wr_addr;
   logic [7:0]          next_wr_data;

   bbs_pkg::bbs_bset_t  bset;
   bbs_pkg::bbs_jump_t  jmp;
   bbs_pkg::bbs_jump_t  in_jmp;
   logic                is_jmp;
   logic                is_bset;
   logic                in_is_jmp;
   logic [PC_W-1:0]     jmp_delta;
   logic [PC_W-1:0]     in_delta;
   logic [AW-1:0]       eff_addr;
   logic [7:0]          rd_data;
   logic [7:0]          bit_mask;
   logic [7:0]          wr_data;
   logic                mem_we;

   assign bset      = bbs_pkg::bbs_bset_t'(ir);
   assign jmp       = bbs_pkg::bbs_jump_t'(ir);
   assign in_jmp    = bbs_pkg::bbs_jump_t'(i_insn);
   assign is_jmp    = (jmp.op == bbs_pkg::OP_JUMP) && !jmp.zero;
   assign is_bset   = (bset.op == bbs_pkg::OP_BITSET);
   assign in_is_jmp = (in_jmp.op == bbs_pkg::OP_JUMP) && !in_jmp.zero;

   // Offset sign-extended and doubled so the counter stays word aligned
   assign jmp_delta = {{(PC_W-12){jmp.offset[10]}}, jmp.offset, 1'b0};
   assign in_delta  = {{(PC_W-12){in_jmp.offset[10]}}, in_jmp.offset, 1'b0};

   ////////////////////////////////////////////////////////////////////////////////////////
   // Operand address

   always_comb
   begin
      if (bset.bank_mode)
      begin
         eff_addr = {i_bank_pointer, bset.file_addr};
      end
      else if (i_ext_en && (bset.file_addr <= bbs_pkg::IDX_LIMIT))
      begin
         eff_addr = i_index_base + AW'(bset.file_addr);
      end
      else if (bset.file_addr < bbs_pkg::ACCESS_SPLIT)
      begin
         eff_addr = {{(AW-8){1'b0}}, bset.file_addr};
      end
      else
      begin
         eff_addr = {{(AW-8){1'b1}}, bset.file_addr};
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Read-modify-write

   assign bit_mask = 8'(8'h01 << bset.bit_idx);
   assign wr_data  = rd_data | bit_mask;
   assign mem_we   = (phase == bbs_pkg::PH_Q4) && !flush && is_bset;

   bbs_filemem #(
      .AW (AW),
      .DW (8)
   ) u_filemem (
      .i_clk_sys  (i_clk_sys),
      .i_reset_n  (i_reset_n),
      .i_rd_addr  (addr),
      .o_rd_data  (rd_data),
      .i_dbg_addr (i_dbg_addr),
      .o_dbg_data (o_dbg_data),
      .i_we       (mem_we),
      .i_wr_addr  (addr),
      .i_wr_data  (wr_data)
   );

   ////////////////////////////////////////////////////////////////////////////////////////
   // Sequencer

   always_comb
   begin
      next_phase     = phase;
      next_flush     = flush;
      next_ir        = ir;
      next_pc        = pc;
      next_addr      = addr;
      next_wr_strobe = mem_we;
      next_wr_addr   = o_wr_addr;
      next_wr_data   = o_wr_data;
      // No status state exists here: only the counter or one file bit moves
      case (phase)
         bbs_pkg::PH_Q1:
         begin
            next_phase = bbs_pkg::PH_Q2;
            if (flush)
            begin
               next_ir = bbs_pkg::INSN_NOP;
            end
            else
            begin
               next_ir = i_insn;
               // Counter moves on at fetch, so a jump adds to the next address
               next_pc = pc + PC_W'(bbs_pkg::PC_STEP);
            end
         end
         bbs_pkg::PH_Q2:
         begin
            next_phase = bbs_pkg::PH_Q3;
            // Address is frozen here so later context changes cannot split the access
            next_addr  = eff_addr;
         end
         bbs_pkg::PH_Q3:
         begin
            next_phase = bbs_pkg::PH_Q4;
         end
         bbs_pkg::PH_Q4:
         begin
            next_phase = bbs_pkg::PH_Q1;
            next_flush = 1'b0;
            if (!flush && is_jmp)
            begin
               next_pc    = pc + jmp_delta;
               next_flush = 1'b1;
            end
            if (mem_we)
            begin
               next_wr_addr = addr;
               next_wr_data = wr_data;
            end
         end
         default:
         begin
            next_phase = bbs_pkg::PH_Q1;
         end
      endcase
   end

   always_ff @(posedge i_clk_sys or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         phase       <= bbs_pkg::PH_Q1;
         flush       <= 1'b0;
         ir          <= bbs_pkg::INSN_NOP;
         pc          <= PC_W'(bbs_pkg::PC_RESET);
         addr        <= '0;
         o_wr_strobe <= 1'b0;
         o_wr_addr   <= '0;
         o_wr_data   <= '0;
      end
      else
      begin
         phase       <= next_phase;
         flush       <= next_flush;
         ir          <= next_ir;
         pc          <= next_pc;
         addr        <= next_addr;
         o_wr_strobe <= next_wr_strobe;
         o_wr_addr   <= next_wr_addr;
         o_wr_data   <= next_wr_data;
      end
   end

   assign o_pc    = pc;
   assign o_phase = phase;
   assign o_flush = flush;

   ////////////////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_reset_n);

   sequence seq_take_jmp;
      (phase == bbs_pkg::PH_Q1) && !flush && in_is_jmp;
   endsequence

   sequence seq_take_bset;
      (phase == bbs_pkg::PH_Q1) && !flush && (i_insn[15:12] == bbs_pkg::OP_BITSET);
   endsequence

   sequence seq_dead_cycle;
      (flush && !mem_we) [*4];
   endsequence

   a_jump_target: assert property (seq_take_jmp |-> ##4
      (pc == PC_W'($past(pc, 4) + PC_W'(bbs_pkg::PC_STEP) + $past(in_delta, 4))))
      else $error("jump target wrong");

   a_jump_dead_cycle: assert property (seq_take_jmp |-> ##4 seq_dead_cycle)
      else $error("jump dead cycle missing");

   a_jump_no_write: assert property (seq_take_jmp |-> ##1 !mem_we [*7])
      else $error("jump wrote the file");

   a_bitset_one_cycle: assert property (seq_take_bset |-> ##3 mem_we ##1
      ((phase == bbs_pkg::PH_Q1) && !flush))
      else $error("bit set not one cycle");

   a_bitset_pc_step: assert property (seq_take_bset |-> ##4
      (pc == PC_W'($past(pc, 4) + PC_W'(bbs_pkg::PC_STEP))))
      else $error("bit set moved counter wrongly");

   // Untouched bits of a never-written byte stay unknown, so they are matched exactly
   a_bit_forced: assert property (mem_we |=> o_wr_strobe
      && o_wr_data[$past(bset.bit_idx)] && (o_wr_addr == $past(addr))
      && ((o_wr_data & ~$past(bit_mask)) === ($past(rd_data) & ~$past(bit_mask))))
      else $error("bit set data wrong");

   a_bank_pointer: assert property (($rose(phase == bbs_pkg::PH_Q3) && is_bset
      && bset.bank_mode) |-> (addr == {$past(i_bank_pointer), bset.file_addr}))
      else $error("banked address wrong");

   a_access_bank: assert property (($rose(phase == bbs_pkg::PH_Q3) && is_bset
      && !bset.bank_mode && !$past(i_ext_en))
      |-> (addr[7:0] == bset.file_addr) && (addr[AW-1:8] == {(AW-8){bset.file_addr[7]}}))
      else $error("access bank address wrong");

   a_indexed_mode: assert property (($rose(phase == bbs_pkg::PH_Q3) && is_bset
      && !bset.bank_mode && $past(i_ext_en) && (bset.file_addr <= bbs_pkg::IDX_LIMIT))
      |-> (addr == AW'($past(i_index_base) + AW'(bset.file_addr))))
      else $error("indexed address wrong");

endmodule

`default_nettype wire

// ===== bbs_exec_tb.sv
// Purpose: Self-checking bench for the branch and bit-set executor.
// Assumes: Inputs change at the falling edge; expectations come from bench functions.
// Notes:   Memory model starts unknown, so untouched bits must stay unknown in the design too.

`timescale 1ns/100ps
`default_nettype none

module bbs_exec_tb;

   logic        i_clk_sys      = 1'b0;
   logic        i_reset_n      = 1'b0;
   logic [15:0] i_insn         = bbs_pkg::INSN_NOP;
   logic [3:0]  i_bank_pointer = 4'h0;
   logic        i_ext_en       = 1'b0;
   logic [11:0] i_index_base   = 12'h000;
   logic [11:0] i_dbg_addr     = 12'h000;
   logic [7:0]  o_dbg_data;
   logic [20:0] o_pc;
   logic [1:0]  o_phase;
   logic        o_flush;
   logic        o_wr_strobe;
   logic [11:0] o_wr_addr;
   logic [7:0]  o_wr_data;
   int          error_cnt = 0;
   int          checks    = 0;
   int          cyc       = 0;
   logic [31:0] seed      = 32'h57dd;
   logic [31:0] r;
   logic [7:0]  mem_m [4096];
   logic [10:0] jo [4] = '{11'h400, 11'h3ff, 11'h000, 11'h7ff};

   bbs_exec i_dut (
      .i_clk_sys      (i_clk_sys),
      .i_reset_n      (i_reset_n),
      .i_insn         (i_insn),
      .i_bank_pointer (i_bank_pointer),
      .i_ext_en       (i_ext_en),
      .i_index_base   (i_index_base),
      .i_dbg_addr     (i_dbg_addr),
      .o_dbg_data     (o_dbg_data),
      .o_pc           (o_pc),
      .o_phase        (o_phase),
      .o_flush        (o_flush),
      .o_wr_strobe    (o_wr_strobe),
      .o_wr_addr      (o_wr_addr),
      .o_wr_data      (o_wr_data)
   );

   always #20 i_clk_sys = ~i_clk_sys;

   // Whole run needs about 700 cycles
   always @(posedge i_clk_sys)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         error_cnt++;
         give_verdict();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic logic [11:0] ea(logic [7:0] f, logic a, logic [3:0] bp, logic x,
                                      logic [11:0] ix);
      if (a)
         return {bp, f};
      if (x && f <= 8'h5f)
         return ix + {4'h0, f};
      return {(f[7] ? 4'hf : 4'h0), f};
   endfunction

   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      checks++;
      if (got !== ex)
      begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", nm, ex, got);
      end
   endtask

   task automatic tick();
      @(negedge i_clk_sys);
   endtask

   task automatic give_verdict();
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Issues one word; dw is driven in the dead cycle of a jump and must be ignored
   task automatic run(input logic [15:0] w, input logic [3:0] bp, input logic x,
                      input logic [11:0] ix, input logic [15:0] dw);
      int          n;
      logic [20:0] a;
      logic [20:0] t;
      logic [11:0] ad;
      n = 0;
      while (!(o_phase === 2'd0 && o_flush === 1'b0) && n < 16)
      begin
         tick();
         n++;
      end
      i_insn = w;
      i_bank_pointer = bp;
      i_ext_en = x;
      i_index_base = ix;
      a = o_pc;
      tick();
      i_insn = bbs_pkg::INSN_NOP;
      chk("pc", {11'h0, a + 21'd2}, {11'h0, o_pc});
      chk("phase", 32'd1, {30'h0, o_phase});
      repeat (2) tick();
      chk("strobe", 32'd0, {31'h0, o_wr_strobe});
      tick();
      if (w[15:11] === {bbs_pkg::OP_JUMP, 1'b0})
      begin
         t = a + 21'd2 + {{9{w[10]}}, w[10:0], 1'b0};
         chk("jump", {11'h0, t}, {11'h0, o_pc});
         chk("flush", 32'd1, {31'h0, o_flush});
         i_insn = dw;
         repeat (4)
         begin
            chk("strobe", 32'd0, {31'h0, o_wr_strobe});
            tick();
            i_insn = bbs_pkg::INSN_NOP;
            chk("dead", {11'h0, t}, {11'h0, o_pc});
         end
         chk("flush", 32'd0, {31'h0, o_flush});
      end
      else if (w[15:12] === bbs_pkg::OP_BITSET)
      begin
         ad = ea(w[7:0], w[8], bp, x, ix);
         mem_m[ad][w[11:9]] = 1'b1;
         chk("wstrobe", 32'd1, {31'h0, o_wr_strobe});
         chk("waddr", {20'h0, ad}, {20'h0, o_wr_addr});
         chk("wdata", {24'h0, mem_m[ad]}, {24'h0, o_wr_data});
         chk("pc", {11'h0, a + 21'd2}, {11'h0, o_pc});
         i_dbg_addr = ad;
         tick();
         chk("pulse", 32'd0, {31'h0, o_wr_strobe});
         chk("mem", {24'h0, mem_m[ad]}, {24'h0, o_dbg_data});
      end
      else
      begin
         chk("nop", {11'h0, a + 21'd2}, {11'h0, o_pc});
         chk("nstrobe", 32'd0, {31'h0, o_wr_strobe});
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////

   initial
   begin
      repeat (5) tick();
      i_reset_n = 1'b1;
      for (int i = 0; i < 4; i++)
         run({5'b11010, jo[i]}, 4'h0, 1'b0, 12'h0, 16'h8e3c);
      $display("test jump bounds done");
      run({4'h8, 3'd1, 1'b1, 8'h0a}, 4'h3, 1'b0, 12'h0, 16'h0);
      run({4'h8, 3'd3, 1'b1, 8'h0a}, 4'h3, 1'b0, 12'h0, 16'h0);
      run({4'h8, 3'd7, 1'b1, 8'h0a}, 4'h3, 1'b1, 12'h0, 16'h0);
      run({4'h8, 3'd0, 1'b0, 8'h5f}, 4'h3, 1'b1, 12'hfff, 16'h0);
      run({4'h8, 3'd2, 1'b0, 8'h60}, 4'h3, 1'b1, 12'h100, 16'h0);
      run({4'h8, 3'd4, 1'b0, 8'h7f}, 4'h5, 1'b0, 12'h100, 16'h0);
      run({4'h8, 3'd5, 1'b0, 8'h80}, 4'h5, 1'b0, 12'h100, 16'h0);
      run({4'h8, 3'd6, 1'b1, 8'hff}, 4'hf, 1'b1, 12'h000, 16'h0);
      $display("test bit-set corners done");
      for (int i = 0; i < 80; i++)
      begin
         r = xs();
         case (r[1:0])
            2'd0:    run({5'b11010, r[26:16]}, 4'h0, 1'b0, 12'h0, r[31:16]);
            2'd3:    run(r[31:16], r[7:4], r[2], r[31:20], 16'h0);
            default: run({4'h8, r[10:8], r[11], r[23:16] & 8'hc7}, {3'h0, r[12]}, r[14],
                         {r[31:24], 4'h0}, 16'h0);
         endcase
      end
      $display("test random mix done");
      give_verdict();
   end

endmodule

`default_nettype wire
